// >>> rxfc_defs.svh
// rxfc_defs.svh: offsets, field positions, reset values and timing counts
// assumes a 20 MHz system clock; included by bare name
`ifndef RXFC_DEFS_SVH
`define RXFC_DEFS_SVH

// register byte offsets on the avalon slave
`define RXFC_CFG_OFFSET 8'hac
`define RXFC_STATUS_OFFSET 8'hb0
`define RXFC_CTRL_OFFSET 8'hb4

// configuration register fields
`define RXFC_HI_MSB 23
`define RXFC_HI_LSB 16
`define RXFC_LO_MSB 15
`define RXFC_LO_LSB 8
`define RXFC_DUR_MSB 7
`define RXFC_DUR_LSB 4
`define RXFC_MULT_BIT 3
`define RXFC_BRD_BIT 2
`define RXFC_ADD_BIT 1
`define RXFC_ANY_BIT 0
`define RXFC_CFG_RESET 32'h0000_0000
`define RXFC_CFG_WMASK 32'h00ff_ffff

// control register fields
`define RXFC_CTRL_FDX_BIT 0
`define RXFC_CTRL_SPD100_BIT 1
`define RXFC_CTRL_TXEN_BIT 2
`define RXFC_CTRL_RESET 32'h0000_0000

// fill level unit, bytes per threshold step (log2 of 64)
`define RXFC_LEVEL_SHIFT 6

// clock rate and the timing of one microsecond
`define RXFC_CLK_MHZ 20
`define RXFC_US_CYCLES (`RXFC_CLK_MHZ)
// extra time at 10 Mb/s, in tenths of a microsecond (2.2 us)
`define RXFC_SLOW_EXTRA_TENTH_US 22
`define RXFC_SLOW_EXTRA_CYCLES ((`RXFC_SLOW_EXTRA_TENTH_US * `RXFC_CLK_MHZ) / 10)

`endif

// >>> rxfc_pkg.sv
// rxfc_pkg.sv: types shared by the flow-control trigger block
// assumes nothing beyond a systemverilog compiler
`default_nettype none
package rxfc_pkg;
    // full-duplex pause sequencing
    typedef enum logic [1:0] {
        RXFC_PAUSE_IDLE,
        RXFC_PAUSE_SENT
    } rxfc_pause_e;
    // duration counter width
    typedef logic [13:0] rxfc_count_t;
endpackage
`default_nettype wire

// >>> rxfc_dur_timer.sv
// rxfc_dur_timer.sv: back pressure duration timer
// assumes a 20 MHz clock; start is a one-cycle pulse
`timescale 1ns/1ns
`include "rxfc_defs.svh"
`default_nettype none
module rxfc_dur_timer
    import rxfc_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // control
    input wire logic start,
    input wire logic [3:0] durCode,
    input wire logic speed100,
    // status
    output logic busy
);
    // microsecond figure per duration code
    function automatic logic [9:0] durUs(input logic [3:0] code);
        logic [9:0] r;
        r = 10'h000;
        unique case (code)
            4'h0: r = 10'h005;
            4'h1: r = 10'h00a;
            4'h2: r = 10'h00f;
            4'h3: r = 10'h019;
            default: r = 10'((code - 4'h3) * 10'h032);
        endcase
        return r;
    endfunction

    rxfc_count_t countReg, countNext; // remaining cycles

    // load on start, else count down to zero
    always_comb begin
        countNext = countReg;
        if (start) begin
            // speed-dependent load so tabulated times hold
            countNext = 14'(durUs(durCode) * 14'(`RXFC_US_CYCLES));
            if (!speed100) begin
                countNext = 14'(countNext + 14'(`RXFC_SLOW_EXTRA_CYCLES));
            end
        end else if (countReg != 14'h0000) begin
            countNext = 14'(countReg - 14'h0001);
        end
    end

    // registered counter
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            countReg <= 14'h0000;
        end else begin
            countReg <= countNext;
        end
    end

    assign busy = (countReg != 14'h0000);
endmodule
`default_nettype wire

// >>> rxfc_trigger.sv
// rxfc_trigger.sv: automatic receive flow-control trigger with avalon slave
// assumes frame-start and address-class pulses from the receive mac
//
// Design decisions made here: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`include "rxfc_defs.svh"
`default_nettype none

// Overview of operation
// - hold back pressure for programmed duration
// - duration codes map 5..600 us, +2.2us slow
// - multicast bit triggers half-duplex back pressure
// - broadcast bit triggers half-duplex back pressure
// - own-address bit triggers half-duplex back pressure
// - any-frame bit: back pressure or pause
// - any-frame half-duplex reacts on valid preamble
// - full-duplex pause requested at threshold immediately
// - any-frame bit overrides other trigger bits
// - duration and trigger bits reset to zero
// - high level counted in 64-byte units
// - one pause per crossing, mac time
// - zero-time pause when fill below low
// - nothing sent while transmitter disabled
module rxfc_trigger
    import rxfc_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // avalon-mm slave
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    // receive side
    input wire logic [13:0] rxFifoBytes,
    input wire logic rxPreamble,
    input wire logic rxFrameMulticast,
    input wire logic rxFrameBroadcast,
    input wire logic rxFrameOwnAddr,
    // mac transmit side
    output logic backPressure,
    output logic pauseRequest,
    output logic pauseZeroTime,
    input wire logic pauseAccepted
);
    logic [31:0] cfgReg, cfgNext;   // flow_control_config
    logic [31:0] ctrlReg, ctrlNext; // link mode and transmitter enable
    logic ackReg, ackNext;          // one wait state per access
    logic [31:0] rdReg, rdNext;     // read data register

    // decoded fields
    logic [7:0] highLevel;
    logic [7:0] lowLevel;
    logic [3:0] durCode;
    logic fullDuplex, speed100, txEnable;
    logic [7:0] fillUnits;
    logic aboveHigh, belowLow;
    logic selMatch, bpStart, bpBusy;

    assign highLevel = cfgReg[`RXFC_HI_MSB:`RXFC_HI_LSB];
    assign lowLevel = cfgReg[`RXFC_LO_MSB:`RXFC_LO_LSB];
    assign durCode = cfgReg[`RXFC_DUR_MSB:`RXFC_DUR_LSB];
    assign fullDuplex = ctrlReg[`RXFC_CTRL_FDX_BIT];
    assign speed100 = ctrlReg[`RXFC_CTRL_SPD100_BIT];
    assign txEnable = ctrlReg[`RXFC_CTRL_TXEN_BIT];

    // fill in 64-byte units; a 14-bit byte count never overflows the field
    assign fillUnits = rxFifoBytes[13:`RXFC_LEVEL_SHIFT];
    assign aboveHigh = (highLevel != 8'h00) && (fillUnits >= highLevel);
    // relies on software keeping low under high
    assign belowLow = (fillUnits < lowLevel);

    // frame selection; any-frame wins and needs only the preamble
    always_comb begin
        selMatch = 1'b0;
        if (cfgReg[`RXFC_ANY_BIT]) begin
            selMatch = rxPreamble;
        end else begin
            selMatch = (cfgReg[`RXFC_MULT_BIT] && rxFrameMulticast)
                     || (cfgReg[`RXFC_BRD_BIT] && rxFrameBroadcast)
                     || (cfgReg[`RXFC_ADD_BIT] && rxFrameOwnAddr);
        end
    end

    // trigger bits ignored in full duplex; silent with tx off
    assign bpStart = !fullDuplex && txEnable && aboveHigh && selMatch && !bpBusy;

    // duration timer
    rxfc_dur_timer uTimer (
        .mclk(mclk),
        .reset_n(reset_n),
        .start(bpStart),
        .durCode(durCode),
        .speed100(speed100),
        .busy(bpBusy)
    );
    // back pressure holds for the full programmed period
    assign backPressure = bpBusy && !fullDuplex && txEnable;

    // full-duplex pause sequencing
    rxfc_pause_e pauseReg, pauseNext;
    logic reqReg, reqNext;     // pause request pending
    logic zeroReg, zeroNext;   // pending request carries zero time

    // one pause per crossing, zero-time pause when drained
    always_comb begin
        pauseNext = pauseReg;
        reqNext = reqReg;
        zeroNext = zeroReg;
        if (reqReg && pauseAccepted) begin
            reqNext = 1'b0; // mac queued it
        end
        unique case (pauseReg)
            RXFC_PAUSE_IDLE: begin
                // immediate request at threshold
                if (fullDuplex && txEnable && cfgReg[`RXFC_ANY_BIT] && aboveHigh && !reqReg) begin
                    pauseNext = RXFC_PAUSE_SENT;
                    reqNext = 1'b1;
                    zeroNext = 1'b0;
                end
            end
            RXFC_PAUSE_SENT: begin
                // wait for the first pause to go, then for drain
                if (!reqReg && belowLow && txEnable) begin
                    pauseNext = RXFC_PAUSE_IDLE;
                    reqNext = 1'b1;
                    zeroNext = 1'b1;
                end else if (!fullDuplex || !cfgReg[`RXFC_ANY_BIT]) begin
                    pauseNext = RXFC_PAUSE_IDLE; // flow control turned off
                end
            end
        endcase
        // drop any pending request while transmitter is off
        if (!txEnable) begin
            reqNext = 1'b0;
        end
    end

    // pause state registers
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            pauseReg <= RXFC_PAUSE_IDLE;
            reqReg <= 1'b0;
            zeroReg <= 1'b0;
        end else begin
            pauseReg <= pauseNext;
            reqReg <= reqNext;
            zeroReg <= zeroNext;
        end
    end
    // pause time itself comes from the mac's own field
    assign pauseRequest = reqReg;
    assign pauseZeroTime = zeroReg;

    // bus slave: answer one cycle after request appears
    always_comb begin
        cfgNext = cfgReg;
        ctrlNext = ctrlReg;
        ackNext = 1'b0;
        rdNext = rdReg;
        if ((read || write) && !ackReg) begin
            ackNext = 1'b1; // wait state ends next cycle
        end
        // a write lands only at the edge where waitrequest is seen low
        if (write && ackReg) begin
            // byte-lane writes; reserved bits stay zero
            for (int i = 0; i < 4; i++) begin
                if (byteenable[i]) begin
                    if (address == `RXFC_CFG_OFFSET) begin
                        cfgNext[i*8 +: 8] = writedata[i*8 +: 8] & 8'(`RXFC_CFG_WMASK >> (i*8));
                    end else if (address == `RXFC_CTRL_OFFSET) begin
                        ctrlNext[i*8 +: 8] = (i == 0) ? (writedata[7:0] & 8'h07) : 8'h00;
                    end
                end
            end
        end
        // read data captured in the wait state, stands when it ends
        if (read && !write && !ackReg) begin
            unique case (address)
                `RXFC_CFG_OFFSET: rdNext = cfgReg;
                `RXFC_CTRL_OFFSET: rdNext = ctrlReg;
                // live state for software
                `RXFC_STATUS_OFFSET: rdNext = {27'h0, zeroReg, reqReg,
                                               pauseReg == RXFC_PAUSE_SENT, aboveHigh, bpBusy};
                default: rdNext = 32'h0000_0000; // unmapped reads zero
            endcase
        end
    end

    // bus registers; fields come up zero
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            cfgReg <= `RXFC_CFG_RESET;
            ctrlReg <= `RXFC_CTRL_RESET;
            ackReg <= 1'b0;
            rdReg <= 32'h0000_0000;
        end else begin
            cfgReg <= cfgNext;
            ctrlReg <= ctrlNext;
            ackReg <= ackNext;
            rdReg <= rdNext;
        end
    end

    assign waitrequest = (read || write) && !ackReg;
    assign readdata = rdReg;
endmodule
`default_nettype wire

// >>> rxfc_trigger_properties.sv
// rxfc_trigger_properties.sv: port-level checker for the flow-control trigger
// assumes one clock domain; bound to every rxfc_trigger below
`timescale 1ns/1ns
`default_nettype none
module rxfc_trigger_properties (
    // clock, reset and bus
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    // receive and mac side
    input wire logic [13:0] rxFifoBytes,
    input wire logic rxPreamble,
    input wire logic rxFrameMulticast,
    input wire logic rxFrameBroadcast,
    input wire logic rxFrameOwnAddr,
    input wire logic backPressure,
    input wire logic pauseRequest,
    input wire logic pauseZeroTime,
    input wire logic pauseAccepted
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    wire logic anyFrame = rxPreamble | rxFrameMulticast | rxFrameBroadcast | rxFrameOwnAddr; // any frame event
    sequence s_taken; (read | write) && waitrequest; endsequence // first bus cycle
    sequence s_open; pauseRequest ##1 pauseRequest; endsequence // request still pending
    property p_oneWait; s_taken |=> !waitrequest; endproperty
    property p_newWait; $rose(read) |-> waitrequest; endproperty
    property p_readStable; !(read && waitrequest) |=> $stable(readdata); endproperty
    property p_bpCause; $rose(backPressure) |-> $past(anyFrame); endproperty
    property p_bpHold; $rose(backPressure) |=> backPressure [*8]; endproperty
    property p_pauseClear; pauseRequest && pauseAccepted |=> !pauseRequest; endproperty
    property p_zeroStable; s_open |-> $stable(pauseZeroTime); endproperty
    property p_pauseFill; $rose(pauseRequest) && !pauseZeroTime |-> $past(rxFifoBytes) >= 14'h0040; endproperty
    property p_pauseNoBp; $rose(pauseRequest) |-> !backPressure; endproperty
    a_oneWait: assert property (p_oneWait) else $error("bus answer late");
    a_newWait: assert property (p_newWait) else $error("read answered at once");
    a_readStable: assert property (p_readStable) else $error("read data moved");
    a_bpCause: assert property (p_bpCause) else $error("back pressure without frame");
    a_bpHold: assert property (p_bpHold) else $error("back pressure too short");
    a_pauseClear: assert property (p_pauseClear) else $error("pause kept after accept");
    a_zeroStable: assert property (p_zeroStable) else $error("pause time kind moved");
    a_pauseFill: assert property (p_pauseFill) else $error("pause below one unit");
    a_pauseNoBp: assert property (p_pauseNoBp) else $error("pause during back pressure");
endmodule
bind rxfc_trigger rxfc_trigger_properties rxfc_trigger_properties_inst (
    .mclk(mclk), .reset_n(reset_n), .read(read), .write(write), .readdata(readdata), .waitrequest(waitrequest),
    .rxFifoBytes(rxFifoBytes), .rxPreamble(rxPreamble), .rxFrameMulticast(rxFrameMulticast),
    .rxFrameBroadcast(rxFrameBroadcast), .rxFrameOwnAddr(rxFrameOwnAddr), .backPressure(backPressure),
    .pauseRequest(pauseRequest), .pauseZeroTime(pauseZeroTime), .pauseAccepted(pauseAccepted)
);
`default_nettype wire

// >>> rxfc_mac_model.sv
// rxfc_mac_model.sv: transmit mac stand-in that takes pause requests
// assumes the bench sets the answer delay in cycles
`timescale 1ns/1ns
`default_nettype none
module rxfc_mac_model (
    // clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // pause handshake
    input wire logic pauseRequest,
    input wire logic [3:0] delay,
    output logic pauseAccepted,
    output var int pauses
);
    int waitCnt; // cycles spent waiting for a send window
    // pause queued until a window opens, one accept per request
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            pauseAccepted <= 1'b0;
            waitCnt <= 0;
            pauses <= 0;
        end else begin
            pauseAccepted <= 1'b0;
            waitCnt <= 0;
            if (pauseRequest && !pauseAccepted && waitCnt >= delay) begin
                pauseAccepted <= 1'b1;
                pauses <= pauses + 1;
            end else if (pauseRequest && !pauseAccepted) begin
                waitCnt <= waitCnt + 1;
            end
        end
    end
endmodule
`default_nettype wire

// >>> tb_top.sv
// tb_top.sv: self-checking bench for the flow-control trigger
// assumes the checker binds itself and the mac model answers pauses
`timescale 1ns/1ns
`include "rxfc_defs.svh"
`default_nettype none
module tb_top;
    logic mclk = 0, reset_n = 0, read = 0, write = 0; // clock, reset, strobes
    logic rxPreamble = 0, rxFrameMulticast = 0, rxFrameBroadcast = 0, rxFrameOwnAddr = 0; // frame pulses
    logic [7:0] address = 8'h00;
    logic [31:0] writedata = 32'h0, readdata, rdVal;
    logic [3:0] byteenable = 4'hf, delay = 4'h0;
    logic [13:0] rxFifoBytes = 14'h0;
    logic waitrequest, backPressure, pauseRequest, pauseZeroTime, pauseAccepted;
    int fails = 0, total_checks = 0, pauses, lastWait; // lastWait: cycles the last pause wait took
    always #25 mclk = ~mclk;
    rxfc_trigger rxfc_trigger_inst (
        .mclk(mclk), .reset_n(reset_n), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
        .rxFifoBytes(rxFifoBytes), .rxPreamble(rxPreamble), .rxFrameMulticast(rxFrameMulticast),
        .rxFrameBroadcast(rxFrameBroadcast), .rxFrameOwnAddr(rxFrameOwnAddr), .backPressure(backPressure),
        .pauseRequest(pauseRequest), .pauseZeroTime(pauseZeroTime), .pauseAccepted(pauseAccepted)
    );
    rxfc_mac_model rxfc_mac_model_inst (
        .mclk(mclk), .reset_n(reset_n), .pauseRequest(pauseRequest), .delay(delay),
        .pauseAccepted(pauseAccepted), .pauses(pauses)
    );
    // verdict and end of run
    task automatic wrap_up;
        $display("checks %0d fails %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one avalon access, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        address <= a;
        writedata <= d;
        write <= wr;
        read <= !wr;
        do begin
            @(posedge mclk);
            n++;
        end while (waitrequest !== 1'b0 && n < 20);
        if (n >= 20) begin
            fails++; // bus never answered
            wrap_up();
        end
        rdVal = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask
    // pulse one frame class, then count back pressure cycles
    task automatic frame(input logic [3:0] sel, input logic [31:0] exp);
        int n;
        n = 0;
        @(posedge mclk);
        {rxFrameMulticast, rxFrameBroadcast, rxFrameOwnAddr, rxPreamble} <= sel;
        @(posedge mclk);
        {rxFrameMulticast, rxFrameBroadcast, rxFrameOwnAddr, rxPreamble} <= 4'h0;
        for (int i = 0; i < 13000 && (backPressure === 1'b1 || i < 3); i++) begin
            @(posedge mclk);
            n += (backPressure === 1'b1);
        end
        chk(n, exp);
    endtask
    task automatic waitReq(input logic lvl);
        int n;
        n = 0;
        while (pauseRequest !== lvl && n < 100) begin
            @(posedge mclk);
            n++;
        end
        lastWait = n;
        if (n >= 100) begin
            fails++; // pause handshake stuck
            wrap_up();
        end
    endtask
    // expected hold time in cycles for a duration code and speed
    function automatic logic [31:0] bpLen(input logic [3:0] c, input logic s100);
        logic [31:0] us;
        us = (c < 4'h3) ? 5 * (c + 1) : (c == 4'h3) ? 25 : 50 * (c - 3);
        return us * `RXFC_US_CYCLES + (s100 ? 0 : `RXFC_SLOW_EXTRA_CYCLES);
    endfunction
    initial begin
        logic [3:0] code, bits;
        logic s100;
        logic [31:0] v;
        void'($urandom(13202));
        repeat (6) @(posedge mclk);
        reset_n <= 1'b1;
        bus(0, `RXFC_CFG_OFFSET, 0);
        chk(rdVal, `RXFC_CFG_RESET);
        bus(1, 8'h40, 32'hffff_ffff);
        bus(0, 8'h40, 0);
        chk(rdVal, 32'h0);
        v = $urandom;
        bus(1, `RXFC_CFG_OFFSET, v);
        bus(0, `RXFC_CFG_OFFSET, 0);
        chk(rdVal, v & `RXFC_CFG_WMASK);
        // one byte lane only: the other lanes keep their value
        byteenable <= 4'h1;
        bus(1, `RXFC_CFG_OFFSET, ~v);
        byteenable <= 4'hf;
        bus(0, `RXFC_CFG_OFFSET, 0);
        chk(rdVal, {v[31:8], ~v[7:0]} & `RXFC_CFG_WMASK);
        // reset in mid-run brings the fields back to zero
        reset_n <= 1'b0;
        repeat (2) @(posedge mclk);
        reset_n <= 1'b1;
        bus(0, `RXFC_CFG_OFFSET, 0);
        chk(rdVal, `RXFC_CFG_RESET);
        $display("test registers done");
        // half duplex, each trigger bit alone, then all bits with any-frame
        for (int i = 0; i < 5; i++) begin
            // longest code first as a corner case, then random shorter ones
            code = (i == 0) ? 4'hf : 4'($urandom % 8);
            s100 = 1'($urandom);
            bits = (i < 4) ? 4'h1 << i : 4'hf;
            bus(1, `RXFC_CTRL_OFFSET, {29'h0, 1'b1, s100, 1'b0});
            bus(1, `RXFC_CFG_OFFSET, {8'h00, 8'h02, 8'h01, code, bits});
            rxFifoBytes <= 14'h0040;
            frame(bits == 4'hf ? 4'h1 : bits, 0);
            rxFifoBytes <= 14'($urandom % 512) + 14'h0080;
            if (i > 0 && i < 4) frame(bits == 4'h8 ? 4'h1 : bits << 1, 0);
            frame(bits == 4'hf ? 4'h1 : bits, bpLen(code, s100));
        end
        $display("test back pressure done");
        // full duplex: one pause per crossing, zero-time pause on drain
        delay <= 4'($urandom % 8);
        rxFifoBytes <= 14'h0;
        bus(1, `RXFC_CTRL_OFFSET, 32'h7);
        bus(0, `RXFC_CTRL_OFFSET, 0);
        chk(rdVal, 32'h0000_0007);
        bus(1, `RXFC_CFG_OFFSET, 32'h0002_01f9);
        rxFifoBytes <= 14'h0100;
        waitReq(1);
        chk(lastWait, 2);
        chk(pauseZeroTime, 0);
        frame(4'h8, 0);
        waitReq(0);
        repeat (30) @(posedge mclk);
        chk(pauses, 1);
        // status: pause sent, still above the high level
        bus(0, `RXFC_STATUS_OFFSET, 0);
        chk(rdVal, 32'h0000_0006);
        rxFifoBytes <= 14'h0020;
        waitReq(1);
        chk(lastWait, 2);
        chk(pauseZeroTime, 1);
        waitReq(0);
        bus(1, `RXFC_CTRL_OFFSET, 32'h3);
        rxFifoBytes <= 14'h0100;
        repeat (30) @(posedge mclk);
        chk(pauses, 2);
        $display("test pause done");
        wrap_up();
    end
endmodule
`default_nettype wire
